//--- common/qrs_params.svh
// Behaviour
// - Valley-skip value stays between 1 and 7
// - Always below low threshold: count up each tick
// - Above low, below high: hold value
// - Above high, below fast threshold: count down
// - Above fast threshold: force 1 next period
// - Steps beyond limits are ignored
// - At most one step per 48 ms tick
// - Falling zero-cross edge increments crossing counter
// - Ringing suppression after turn-off, long or short
// - Overvoltage while off latches off after blanking
// - Turn on when counters match and zero-cross low
// - Maximum off-time clock also triggers turn-on
// - Burst mode disables counter-match turn-on
// - Scaled sense above regulation turns switch off
// - Current comparator blanked 330 ns after turn-on
// - Current limit lower for shorter on-time
// - Burst entry: low regulation, count 7, 24 ms
// - Burst pause ends above burst-high threshold
// - Burst turn-on from fixed 80 kHz timer
// - Burst turn-off: burst limit or 50 % duty
// - Burst-low threshold pauses switching again
// - Burst exit: full limit, force count 1
`ifndef QRS_PARAMS_SVH
`define QRS_PARAMS_SVH

`define QRS_CLK_MHZ 200
`define QRS_VSKIP_MIN 3'h1
`define QRS_VSKIP_MAX 3'h7
`define QRS_VSKIP_RST 3'h1
`define QRS_ZCC_RST 3'h0
`define QRS_ZCC_MAX 3'h7

`define QRS_TICK_MS 48
`define QRS_TICK_CYC (`QRS_TICK_MS * `QRS_CLK_MHZ * 1000)
`define QRS_BURST_BLANK_MS 24
`define QRS_BURST_BLANK_CYC (`QRS_BURST_BLANK_MS * `QRS_CLK_MHZ * 1000)
`define QRS_MAX_OFF_US 50
`define QRS_MAX_OFF_CYC (`QRS_MAX_OFF_US * `QRS_CLK_MHZ)

`define QRS_LEB_NS 330
`define QRS_LEB_CYC ((`QRS_LEB_NS * `QRS_CLK_MHZ + 999) / 1000)
`define QRS_RING_LONG_NS 2500
`define QRS_RING_LONG_CYC ((`QRS_RING_LONG_NS * `QRS_CLK_MHZ + 999) / 1000)
`define QRS_RING_SHORT_NS 1000
`define QRS_RING_SHORT_CYC ((`QRS_RING_SHORT_NS * `QRS_CLK_MHZ + 999) / 1000)
`define QRS_OVP_BLANK_NS 1000
`define QRS_OVP_BLANK_CYC ((`QRS_OVP_BLANK_NS * `QRS_CLK_MHZ + 999) / 1000)

`define QRS_BURST_KHZ 80
`define QRS_BURST_PERIOD_CYC (`QRS_CLK_MHZ * 1000 / `QRS_BURST_KHZ)
`define QRS_BURST_DUTY_PCT 50
`define QRS_BURST_ON_CYC (`QRS_BURST_PERIOD_CYC * `QRS_BURST_DUTY_PCT / 100)

`define QRS_FOLD_STEP_NS 1000
`define QRS_FOLD_STEP_CYC (`QRS_FOLD_STEP_NS * `QRS_CLK_MHZ / 1000)
`define QRS_FOLD_SEL_MAX 3'h7

`endif

//--- common/qrs_pkg.sv
package qrs_pkg;

  typedef enum logic [1:0] {
    QRS_NORMAL      = 2'b00,
    QRS_BURST_PAUSE = 2'b01,
    QRS_BURST_RUN   = 2'b10,
    QRS_LATCHED     = 2'b11
  } qrs_mode_t;

  // Analog comparator outputs, high when the named level is exceeded
  typedef struct packed {
    logic reg_above_low;
    logic reg_above_high;
    logic reg_above_fast;
    logic zc_above_t1;
    logic zc_above_t2;
    logic zc_above_ovp;
    logic cs_above_reg;
    logic cs_above_fold;
    logic cs_above_burst;
    logic reg_above_entry;
    logic reg_above_bhigh;
    logic reg_above_blow;
    logic reg_above_exit;
  } qrs_cmp_t;

  typedef struct packed {
    qrs_mode_t mode;
    logic bias_on;
    logic full_limit;
    logic latched;
    logic [2:0] vskip;
    logic [2:0] zcc;
    logic [2:0] fold_sel;
  } qrs_stat_t;

endpackage

//--- verilog/qrs_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "qrs_params.svh"

module qrs_core #(
  parameter int unsigned TICK_CYC = `QRS_TICK_CYC,
  parameter int unsigned BURST_BLANK_CYC = `QRS_BURST_BLANK_CYC,
  parameter int unsigned MAX_OFF_CYC = `QRS_MAX_OFF_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Comparator outputs from the analog side
  input wire qrs_pkg::qrs_cmp_t cmp_i,
  // Power switch gate
  output logic gate_o,
  // Control state
  output qrs_pkg::qrs_stat_t stat_o
);
  import qrs_pkg::*;

  localparam logic [23:0] TICK_LAST = 24'(TICK_CYC - 1);
  localparam logic [23:0] BLANK_LAST = 24'(BURST_BLANK_CYC - 1);
  localparam logic [23:0] MAX_OFF_LAST = 24'(MAX_OFF_CYC - 1);
  localparam logic [11:0] LEB_CYC = 12'(`QRS_LEB_CYC);
  localparam logic [11:0] RING_LONG = 12'(`QRS_RING_LONG_CYC);
  localparam logic [11:0] RING_SHORT = 12'(`QRS_RING_SHORT_CYC);
  localparam logic [11:0] OVP_LAST = 12'(`QRS_OVP_BLANK_CYC - 1);
  localparam logic [11:0] BURST_LAST = 12'(`QRS_BURST_PERIOD_CYC - 1);
  localparam logic [11:0] BURST_ON = 12'(`QRS_BURST_ON_CYC);
  localparam logic [11:0] FOLD_STEP = 12'(`QRS_FOLD_STEP_CYC);

  function automatic logic [2:0] qrs_sat_step(input logic [2:0] v, input logic up);
    if (up) begin
      qrs_sat_step = (v == `QRS_VSKIP_MAX) ? v : 3'(v + 3'h1);
    end else begin
      qrs_sat_step = (v == `QRS_VSKIP_MIN) ? v : 3'(v - 3'h1);
    end
  endfunction

  qrs_cmp_t cmp_meta_reg;
  qrs_cmp_t cmp_reg;
  logic zc_t1_prev_reg;
  logic [23:0] tick_cnt_reg;
  logic tick;
  logic seen_low_reg;
  logic seen_high_reg;
  logic fast_pend_reg;
  logic [2:0] vskip_reg;
  logic [2:0] zcc_reg;
  logic [11:0] ring_cnt_reg;
  logic [11:0] on_cnt_reg;
  logic [23:0] off_cnt_reg;
  logic [11:0] ovp_cnt_reg;
  logic [23:0] blank_cnt_reg;
  logic [11:0] burst_cnt_reg;
  logic [2:0] fold_sel_reg;
  logic gate_reg;
  qrs_mode_t mode_reg;
  qrs_mode_t mode_next;
  logic zc_pulse;
  logic leb_done;
  logic ovp_trip;
  logic burst_entry;
  logic burst_exit;
  logic turn_on;
  logic turn_off;
  logic gate_fall;

  // Two-stage synchroniser on every comparator output
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmp_meta_reg <= '0;
      cmp_reg <= '0;
    end else begin
      cmp_meta_reg <= cmp_i;
      cmp_reg <= cmp_meta_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      zc_t1_prev_reg <= 1'b0;
    end else begin
      zc_t1_prev_reg <= cmp_reg.zc_above_t1;
    end
  end

  // Tick generator for the valley-skip counter
  assign tick = (tick_cnt_reg == TICK_LAST);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= 24'(tick_cnt_reg + 24'h1);
    end
  end

  // Threshold crossings seen during the current tick period
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seen_low_reg <= 1'b0;
      seen_high_reg <= 1'b0;
    end else if (tick) begin
      seen_low_reg <= cmp_reg.reg_above_low;
      seen_high_reg <= cmp_reg.reg_above_high;
    end else begin
      seen_low_reg <= seen_low_reg | cmp_reg.reg_above_low;
      seen_high_reg <= seen_high_reg | cmp_reg.reg_above_high;
    end
  end

  assign gate_fall = gate_reg & turn_off;

  // Fast-response request, served at the next turn-off of the switch
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fast_pend_reg <= 1'b0;
    end else if (cmp_reg.reg_above_fast) begin
      fast_pend_reg <= 1'b1;
    end else if (gate_fall || burst_exit) begin
      fast_pend_reg <= 1'b0;
    end
  end

  // Valley-skip counter
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vskip_reg <= `QRS_VSKIP_RST;
    end else if (burst_exit) begin
      vskip_reg <= `QRS_VSKIP_MIN;
    end else if (fast_pend_reg && gate_fall) begin
      vskip_reg <= `QRS_VSKIP_MIN;
    end else if (tick && !fast_pend_reg) begin
      if (!seen_low_reg) begin
        vskip_reg <= qrs_sat_step(vskip_reg, 1'b1);
      end else if (seen_high_reg) begin
        vskip_reg <= qrs_sat_step(vskip_reg, 1'b0);
      end
      // Between low and high thresholds the value is held
    end
  end

  // Zero-crossing detection with ringing suppression
  assign zc_pulse = zc_t1_prev_reg & ~cmp_reg.zc_above_t1 & (ring_cnt_reg == 12'h0)
    & ~gate_reg;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ring_cnt_reg <= '0;
    end else if (gate_fall) begin
      ring_cnt_reg <= cmp_reg.zc_above_t2 ? RING_SHORT : RING_LONG;
    end else if (ring_cnt_reg != 12'h0) begin
      ring_cnt_reg <= 12'(ring_cnt_reg - 12'h1);
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      zcc_reg <= `QRS_ZCC_RST;
    end else if (gate_reg) begin
      zcc_reg <= `QRS_ZCC_RST;
    end else if (zc_pulse && zcc_reg != `QRS_ZCC_MAX) begin
      zcc_reg <= 3'(zcc_reg + 3'h1);
    end
  end

  // On-time, off-time and foldback limit selection
  assign leb_done = (on_cnt_reg >= LEB_CYC);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      on_cnt_reg <= '0;
    end else if (!gate_reg) begin
      on_cnt_reg <= '0;
    end else if (on_cnt_reg != 12'hfff) begin
      on_cnt_reg <= 12'(on_cnt_reg + 12'h1);
    end
  end

  // Limit index rises with elapsed on-time
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fold_sel_reg <= '0;
    end else if (!gate_reg) begin
      fold_sel_reg <= '0;
    end else if (on_cnt_reg >= FOLD_STEP * (12'(fold_sel_reg) + 12'h1)
        && fold_sel_reg != `QRS_FOLD_SEL_MAX) begin
      fold_sel_reg <= 3'(fold_sel_reg + 3'h1);
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      off_cnt_reg <= '0;
    end else if (gate_reg || mode_reg != QRS_NORMAL) begin
      off_cnt_reg <= '0;
    end else if (off_cnt_reg != MAX_OFF_LAST) begin
      off_cnt_reg <= 24'(off_cnt_reg + 24'h1);
    end
  end

  // Output overvoltage blanking while the switch is off
  assign ovp_trip = (ovp_cnt_reg == OVP_LAST) & cmp_reg.zc_above_ovp & ~gate_reg;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovp_cnt_reg <= '0;
    end else if (gate_reg || !cmp_reg.zc_above_ovp) begin
      ovp_cnt_reg <= '0;
    end else if (ovp_cnt_reg != OVP_LAST) begin
      ovp_cnt_reg <= 12'(ovp_cnt_reg + 12'h1);
    end
  end

  // Burst entry blanking
  assign burst_entry = (blank_cnt_reg == BLANK_LAST);
  assign burst_exit = cmp_reg.reg_above_exit
    & (mode_reg == QRS_BURST_PAUSE || mode_reg == QRS_BURST_RUN);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      blank_cnt_reg <= '0;
    end else if (mode_reg != QRS_NORMAL || cmp_reg.reg_above_entry
        || vskip_reg != `QRS_VSKIP_MAX) begin
      blank_cnt_reg <= '0;
    end else if (!burst_entry) begin
      blank_cnt_reg <= 24'(blank_cnt_reg + 24'h1);
    end
  end

  // Operating mode
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      QRS_NORMAL: begin
        if (burst_entry) begin
          mode_next = QRS_BURST_PAUSE;
        end
      end
      QRS_BURST_PAUSE: begin
        if (burst_exit) begin
          mode_next = QRS_NORMAL;
        end else if (cmp_reg.reg_above_bhigh) begin
          mode_next = QRS_BURST_RUN;
        end
      end
      QRS_BURST_RUN: begin
        if (burst_exit) begin
          mode_next = QRS_NORMAL;
        end else if (!cmp_reg.reg_above_blow) begin
          mode_next = QRS_BURST_PAUSE;
        end
      end
      QRS_LATCHED: begin
        mode_next = QRS_LATCHED;
      end
    endcase
    if (ovp_trip) begin
      mode_next = QRS_LATCHED;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_reg <= QRS_NORMAL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Fixed-frequency burst timer, restarted on each burst run
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      burst_cnt_reg <= '0;
    end else if (mode_reg != QRS_BURST_RUN || burst_cnt_reg == BURST_LAST) begin
      burst_cnt_reg <= '0;
    end else begin
      burst_cnt_reg <= 12'(burst_cnt_reg + 12'h1);
    end
  end

  // Turn-on and turn-off decisions
  always_comb begin
    turn_on = 1'b0;
    turn_off = 1'b0;
    unique case (mode_reg)
      QRS_NORMAL: begin
        turn_on = ((zcc_reg == vskip_reg && !cmp_reg.zc_above_t1 && ring_cnt_reg == 12'h0)
          || off_cnt_reg == MAX_OFF_LAST) && !burst_entry;
        turn_off = leb_done && (cmp_reg.cs_above_reg || cmp_reg.cs_above_fold);
      end
      QRS_BURST_RUN: begin
        turn_on = (burst_cnt_reg == 12'h0) && !burst_exit;
        turn_off = (leb_done && cmp_reg.cs_above_burst)
          || on_cnt_reg >= BURST_ON - 12'h1;
      end
      QRS_BURST_PAUSE: begin
        turn_off = 1'b1;
      end
      QRS_LATCHED: begin
        turn_off = 1'b1;
      end
    endcase
    if (mode_next != mode_reg) begin
      turn_on = 1'b0;
      turn_off = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gate_reg <= 1'b0;
    end else if (gate_reg) begin
      gate_reg <= ~turn_off;
    end else begin
      gate_reg <= turn_on;
    end
  end

  assign gate_o = gate_reg;
  assign stat_o.mode = mode_reg;
  assign stat_o.bias_on = (mode_reg == QRS_NORMAL) || (mode_reg == QRS_BURST_RUN);
  assign stat_o.full_limit = (mode_reg == QRS_NORMAL);
  assign stat_o.latched = (mode_reg == QRS_LATCHED);
  assign stat_o.vskip = vskip_reg;
  assign stat_o.zcc = zcc_reg;
  assign stat_o.fold_sel = fold_sel_reg;

endmodule

`default_nettype wire

//--- tb/qrs_core_chk.sv
`timescale 1ns/10ps
`default_nettype none
module qrs_core_chk #(
  parameter int unsigned MAX_OFF_CYC = 10000
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire qrs_pkg::qrs_cmp_t cmp_i,
  input wire logic gate_o,
  input wire qrs_pkg::qrs_stat_t stat_o
);
  import qrs_pkg::*;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  int unsigned on_cnt;
  int unsigned off_cnt;
  // Length of the current on and normal-mode off intervals
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      on_cnt <= 0;
    end else begin
      on_cnt <= gate_o ? on_cnt + 1 : 0;
    end
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      off_cnt <= 0;
    end else begin
      off_cnt <= (!gate_o && stat_o.mode == QRS_NORMAL) ? off_cnt + 1 : 0;
    end
  end
  AST_VSKIP_RANGE: assert property (
    stat_o.vskip != 3'h0) else $error("valley count left its range");
  AST_VSKIP_STEP: assert property (
    !$stable(stat_o.vskip) |-> stat_o.vskip == $past(stat_o.vskip) + 3'h1
    || stat_o.vskip == $past(stat_o.vskip) - 3'h1 || stat_o.vskip == 3'h1)
    else $error("valley count jumped");
  AST_LEB: assert property (
    $fell(gate_o) && $stable(stat_o.mode) |-> on_cnt >= 66)
    else $error("turn-off inside blanking");
  AST_BURST_DUTY: assert property (
    stat_o.mode == QRS_BURST_RUN |-> on_cnt <= 1250) else $error("burst duty exceeded");
  AST_PAUSE_OFF: assert property (
    (stat_o.mode == QRS_BURST_PAUSE) [*2] |-> !gate_o) else $error("gate on in pause");
  AST_LATCH: assert property (
    stat_o.mode == QRS_LATCHED |=> stat_o.mode == QRS_LATCHED && !gate_o)
    else $error("latch released");
  AST_ENTRY: assert property (
    stat_o.mode == QRS_BURST_PAUSE && $past(stat_o.mode) == QRS_NORMAL
    |-> $past(stat_o.vskip) == 3'h7) else $error("burst entered below count 7");
  AST_EXIT: assert property (
    $past(stat_o.mode) inside {QRS_BURST_PAUSE, QRS_BURST_RUN}
    && stat_o.mode == QRS_NORMAL |-> stat_o.vskip == 3'h1 && stat_o.full_limit)
    else $error("burst exit without count 1");
  AST_BIAS: assert property (
    stat_o.mode inside {QRS_BURST_PAUSE, QRS_BURST_RUN} |-> !stat_o.full_limit
    && stat_o.bias_on == (stat_o.mode == QRS_BURST_RUN)) else $error("bias wrong");
  AST_MAX_OFF: assert property (
    off_cnt <= MAX_OFF_CYC + 4) else $error("off time too long");
  AST_MATCH_ON: assert property (
    $rose(gate_o) && stat_o.mode == QRS_NORMAL && off_cnt + 8 < MAX_OFF_CYC
    |-> $past(stat_o.zcc) == $past(stat_o.vskip)) else $error("turn-on without match");
  COV_NORMAL_ON: cover property ($rose(gate_o) && stat_o.mode == QRS_NORMAL);
  COV_BURST_ON: cover property ($rose(gate_o) && stat_o.mode == QRS_BURST_RUN);
  COV_LATCH: cover property (stat_o.mode == QRS_LATCHED);
endmodule
bind qrs_core qrs_core_chk #(.MAX_OFF_CYC(MAX_OFF_CYC)) i_chk (.core_clk_i(core_clk_i),
  .resetn_i(resetn_i), .cmp_i(cmp_i), .gate_o(gate_o), .stat_o(stat_o));
`default_nettype wire

//--- tb/qrs_plant.sv
`timescale 1ns/10ps
`default_nettype none
module qrs_plant (
  input wire logic core_clk_i,
  input wire logic gate_i,
  input wire qrs_pkg::qrs_cmp_t lvl_i,
  input wire logic [15:0] on_len_i,
  input wire logic [15:0] ring_i,
  output qrs_pkg::qrs_cmp_t cmp_o
);
  import qrs_pkg::*;
  logic gate_q = 1'b0;
  int t = 0;
  qrs_cmp_t c;
  initial cmp_o = '0;
  // Sense ramps with on-time; zero-cross rings after turn-off, low while on
  always @(posedge core_clk_i) begin
    gate_q <= gate_i;
    t <= (gate_i !== gate_q) ? 1 : t + 1;
    c = lvl_i;
    c.cs_above_reg = gate_i && t >= on_len_i;
    c.cs_above_fold = gate_i && t >= 2 * on_len_i;
    c.cs_above_burst = gate_i && t >= on_len_i / 2;
    c.zc_above_t1 = !gate_i && (t / ring_i) % 2 == 0;
    c.zc_above_t2 = c.zc_above_t1 && t < ring_i;
    cmp_o <= #1 c;
  end
endmodule
`default_nettype wire

//--- tb/qrs_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module qrs_core_tb;
  import qrs_pkg::*;
  logic core_clk_i;
  logic resetn_i;
  qrs_cmp_t lvl;
  qrs_cmp_t cmp;
  logic gate;
  qrs_stat_t st;
  logic [15:0] on_len;
  logic [15:0] ring;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  // Max off time kept above the long ringing time so that valleys can win
  qrs_core #(.TICK_CYC(64), .BURST_BLANK_CYC(32), .MAX_OFF_CYC(1000)) i_dut (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .cmp_i(cmp), .gate_o(gate),
    .stat_o(st));
  qrs_plant i_plant (.core_clk_i(core_clk_i), .gate_i(gate), .lvl_i(lvl),
    .on_len_i(on_len), .ring_i(ring), .cmp_o(cmp));
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  function automatic logic [2:0] sat(input int v);
    return (v > 7) ? 3'h7 : (v < 1) ? 3'h1 : 3'(v);
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic clk(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wait_gate(input logic v, input int lim, output int k);
    for (k = 0; k < lim && gate !== v; k++) clk(1);
  endtask
  task automatic wait_mode(input qrs_mode_t m, input int lim);
    for (int k = 0; k < lim && st.mode !== m; k++) clk(1);
    chk("mode", st.mode, m);
  endtask
  task automatic rst();
    resetn_i = 1'b0;
    clk(3);
    resetn_i = 1'b1;
  endtask
  initial begin
    resetn_i = 1'b0;
    lvl = '0;
    lvl.reg_above_low = 1'b1;
    lvl.reg_above_entry = 1'b1;
    on_len = 16'h50;
    ring = 16'h1e;
    n = $urandom(58);
    rst();
    chk("vskip", st.vskip, 3'h1);
    chk("gate", gate, 1'b0);
    ring = 16'h14 + 16'($urandom % 40);
    wait_gate(1'b1, 1000, n);
    chk("valley_zcc", st.zcc, 3'h1);
    wait_gate(1'b0, 1000, n);
    wait_gate(1'b1, 1000, n);
    // Long suppression after turn-off, then the first valley
    chk("valley_on", n >= 500 && n < 700, 1'b1);
    ring = 16'hffff;
    on_len = 16'ha;
    wait_gate(1'b0, 1000, n);
    wait_gate(1'b1, 1000, n);
    chk("max_off", n >= 996 && n <= 1006, 1'b1);
    wait_gate(1'b0, 200, n);
    chk("blanking", n >= 64 && n <= 72, 1'b1);
    $display("test switching done");
    ring = 16'h14 + 16'($urandom % 40);
    on_len = 16'h46 + 16'($urandom % 100);
    lvl.reg_above_low = 1'b0;
    n = 8 + $urandom % 4;
    clk(64 * n);
    chk("count_up", st.vskip, sat(1 + n));
    lvl.reg_above_low = 1'b1;
    clk(64 * 4);
    chk("hold", st.vskip, 3'h7);
    lvl.reg_above_high = 1'b1;
    clk(64 * 3);
    chk("count_down", st.vskip >= 3'h3 && st.vskip <= 3'h5, 1'b1);
    clk(64 * 8);
    chk("down_sat", st.vskip, 3'h1);
    lvl.reg_above_high = 1'b0;
    lvl.reg_above_low = 1'b0;
    clk(64 * 8);
    lvl.reg_above_low = 1'b1;
    lvl.reg_above_high = 1'b1;
    lvl.reg_above_fast = 1'b1;
    clk(10);
    lvl.reg_above_high = 1'b0;
    lvl.reg_above_fast = 1'b0;
    for (n = 0; n < 2000 && st.vskip !== 3'h1; n++) clk(1);
    chk("fast_force", st.vskip, 3'h1);
    $display("test valley count done");
    lvl.reg_above_low = 1'b0;
    clk(64 * 8);
    lvl.reg_above_entry = 1'b0;
    lvl.reg_above_blow = 1'b1;
    wait_mode(QRS_BURST_PAUSE, 200);
    chk("pause_bias", st.bias_on, 1'b0);
    chk("pause_gate", gate, 1'b0);
    on_len = 16'hfa0;
    lvl.reg_above_bhigh = 1'b1;
    wait_mode(QRS_BURST_RUN, 20);
    chk("run_bias", st.bias_on, 1'b1);
    wait_gate(1'b1, 3000, n);
    clk(700);
    // One limit step per 200 cycles of on-time
    chk("fold_sel", st.fold_sel, 3'h3);
    wait_gate(1'b0, 3000, n);
    chk("burst_on", n + 700, 1250);
    wait_gate(1'b1, 3000, n);
    chk("burst_off", n, 1250);
    lvl.reg_above_blow = 1'b0;
    lvl.reg_above_bhigh = 1'b0;
    wait_mode(QRS_BURST_PAUSE, 20);
    clk(50);
    chk("pause_gate", gate, 1'b0);
    lvl = '1;
    lvl.reg_above_high = 1'b0;
    lvl.reg_above_fast = 1'b0;
    lvl.zc_above_ovp = 1'b0;
    wait_mode(QRS_NORMAL, 20);
    chk("exit_vskip", st.vskip, 3'h1);
    chk("full_limit", st.full_limit, 1'b1);
    $display("test burst done");
    on_len = 16'h50;
    ring = 16'hffff;
    lvl.zc_above_ovp = 1'b1;
    wait_mode(QRS_LATCHED, 1000);
    chk("latched", st.latched, 1'b1);
    clk(500);
    chk("latched_gate", gate, 1'b0);
    lvl.zc_above_ovp = 1'b0;
    rst();
    chk("mode", st.mode, QRS_NORMAL);
    $display("test overvoltage done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
